/* hdl/mbt_bitop.sv */
`include "mbt_defs.svh"
// Bit select, mask, increment, decrement and nibble swap of one byte
module mbt_bitop (
	input wire logic [7:0] i_val,
	input wire logic [2:0] i_bitn,
	output logic o_bit,
	output logic [7:0] o_clr,
	output logic [7:0] o_set,
	output logic [7:0] o_inc,
	output logic [7:0] o_dec,
	output logic [7:0] o_swap
);
	logic [7:0] mask;
	// One-hot mask of the chosen bit
	always_comb begin
		mask = `MBT_ZERO8;
		mask[i_bitn] = 1'b1;
	end
	// Results; clear and set leave other bits untouched
	assign o_bit = i_val[i_bitn];
	assign o_clr = i_val & ~mask;
	assign o_set = i_val | mask;
	assign o_inc = i_val + `MBT_ONE8;
	assign o_dec = i_val - `MBT_ONE8;
	assign o_swap = {i_val[3:0], i_val[7:4]};
endmodule

/* hdl/mbt_exec.sv */
// Overview of operation
// - Memory byte to accumulator, one cycle, flags kept
// - Accumulator to memory byte, one cycle, flags kept
// - Immediate to accumulator, one cycle, no flags
// - Bit clear/set touches only chosen bit
// - Skip next when byte zero / nonzero
// - Zero-skip-move also copies byte to accumulator
// - Bit test skips on zero or nonzero bit
// - Inc/dec skip writes memory, skips on zero
// - Accumulator inc/dec skip keeps memory unchanged
// - Skip: three cycles, else one
// - Program counter changes take two cycles
// - Return-immediate restores address, loads accumulator
// - Table fetch: low to memory, high register
// - Last-page table fetch uses final page
// - Incrementing forms bump pointer, then fetch
// - Nibble swap; accumulator form keeps memory
// - Watchdog clear clears both flags; halt clears timeout, sets power down; others keep
// - Halt enters power down in one cycle
// - Extended forms reach any data sector directly
// - Standard forms address only sector zero
`include "mbt_defs.svh"
module mbt_exec #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire mbt_pkg::mbt_instr_t i_instr,
	input wire logic [7:0] i_dmem_rdata,
	input wire logic [15:0] i_pmem_rdata,
	input wire logic [7:0] i_table_page,
	input wire logic i_wake,
	output logic o_ready,
	output logic [1:0] o_dmem_sect,
	output logic [7:0] o_dmem_raddr,
	output mbt_pkg::mbt_dwr_t o_dmem_wr,
	output logic [15:0] o_pmem_addr,
	output logic [11:0] o_pc,
	output logic [7:0] o_accumulator_reg,
	output logic [7:0] o_table_high_byte,
	output logic [7:0] o_table_pointer,
	output logic o_timeout_flag,
	output logic o_powerdown_flag,
	output logic o_halted
);
	import mbt_pkg::*;
	localparam int SPW = $clog2(STACK_DEPTH);
	// Stack pointer wraps, so the depth must fill its index exactly
	if (STACK_DEPTH < 2 || STACK_DEPTH > 16 || (1 << SPW) != STACK_DEPTH) begin : g_depth_chk
		$error("STACK_DEPTH must be a power of two from 2 to 16");
	end

	mbt_state_t st_ff, nxt_st;
	logic [11:0] pc_ff, nxt_pc;
	logic [7:0] acc_ff, nxt_acc, thi_ff, nxt_thi, tptr_ff, nxt_tptr;
	logic to_ff, nxt_to, pdn_ff, nxt_pdn;
	logic [1:0] wait_ff, nxt_wait;
	mbt_dwr_t wr_ff, nxt_wr;
	logic [1:0] tsect_ff, nxt_tsect;
	logic [7:0] taddr_ff, nxt_taddr;
	logic [15:0] paddr_ff, nxt_paddr;
	logic [11:0] stack_ff [STACK_DEPTH];
	logic [SPW-1:0] sp_ff, nxt_sp;
	logic push, pop;
	logic [1:0] sect;
	logic bit_v;
	logic skip;
	logic [7:0] v_clr, v_set, v_inc, v_dec, v_swap, res, fetch_ptr, rd_eff;

	// Standard forms see sector zero, extended forms their own sector
	assign sect = i_instr.ext ? i_instr.sect : `MBT_SECTOR0;
	assign o_dmem_sect = sect;
	assign o_dmem_raddr = i_instr.addr;
	// A write still in flight shadows the stale memory byte at the same address
	assign rd_eff = (wr_ff.we && wr_ff.sect == sect && wr_ff.addr == i_instr.addr)
		? wr_ff.data : i_dmem_rdata;

	mbt_bitop u_bitop (
		.i_val(rd_eff),
		.i_bitn(i_instr.bitn),
		.o_bit(bit_v),
		.o_clr(v_clr),
		.o_set(v_set),
		.o_inc(v_inc),
		.o_dec(v_dec),
		.o_swap(v_swap)
	);

	// Instruction accepted only in execute state
	assign o_ready = (st_ff == MBT_S_EXEC);

	// Next state for core registers
	always_comb begin
		nxt_st = st_ff;
		nxt_pc = pc_ff;
		nxt_acc = acc_ff;
		nxt_thi = thi_ff;
		nxt_tptr = tptr_ff;
		nxt_to = to_ff;
		nxt_pdn = pdn_ff;
		nxt_wait = wait_ff;
		nxt_wr = '0;
		nxt_tsect = tsect_ff;
		nxt_taddr = taddr_ff;
		nxt_paddr = paddr_ff;
		nxt_sp = sp_ff;
		push = 1'b0;
		pop = 1'b0;
		skip = 1'b0;
		res = rd_eff;
		fetch_ptr = tptr_ff;
		case (st_ff)
			MBT_S_EXEC: begin
				if (i_valid) begin
					nxt_pc = pc_ff + `MBT_ONE_PC;
					case (i_instr.op)
						MBT_NOP: begin
							nxt_pc = pc_ff + `MBT_ONE_PC;
						end
						MBT_MOV_MA: begin
							nxt_acc = rd_eff;
						end
						MBT_MOV_AM: begin
							nxt_wr = '{1'b1, sect, i_instr.addr, acc_ff};
						end
						MBT_MOV_AX: begin
							nxt_acc = i_instr.addr;
						end
						MBT_BCLR: begin
							nxt_wr = '{1'b1, sect, i_instr.addr, v_clr};
						end
						MBT_BSET: begin
							nxt_wr = '{1'b1, sect, i_instr.addr, v_set};
						end
						MBT_CLRM: begin
							nxt_wr = '{1'b1, sect, i_instr.addr, `MBT_ZERO8};
						end
						MBT_SETM: begin
							nxt_wr = '{1'b1, sect, i_instr.addr, `MBT_ONES8};
						end
						MBT_SWAP: begin
							nxt_wr = '{1'b1, sect, i_instr.addr, v_swap};
						end
						MBT_SWAPACC: begin
							nxt_acc = v_swap;
						end
						MBT_SKZ, MBT_SKZM, MBT_SKNZ, MBT_SKBZ, MBT_SKBNZ,
						MBT_INCSK, MBT_DECSK, MBT_INCSKA, MBT_DECSKA: begin
							case (i_instr.op)
								MBT_SKZ: skip = (rd_eff == `MBT_ZERO8);
								MBT_SKNZ: skip = (rd_eff != `MBT_ZERO8);
								MBT_SKZM: begin
									nxt_acc = rd_eff;
									skip = (rd_eff == `MBT_ZERO8);
								end
								MBT_SKBZ: skip = !bit_v;
								MBT_SKBNZ: skip = bit_v;
								MBT_INCSK, MBT_INCSKA: res = v_inc;
								MBT_DECSK, MBT_DECSKA: res = v_dec;
								default: skip = 1'b0;
							endcase
							if (i_instr.op == MBT_INCSK || i_instr.op == MBT_DECSK) begin
								nxt_wr = '{1'b1, sect, i_instr.addr, res};
								skip = (res == `MBT_ZERO8);
							end
							if (i_instr.op == MBT_INCSKA || i_instr.op == MBT_DECSKA) begin
								nxt_acc = res;
								skip = (res == `MBT_ZERO8);
							end
							if (skip) begin
								nxt_pc = pc_ff + `MBT_TWO_PC;
								nxt_wait = `MBT_SKIP_WAIT;
								nxt_st = MBT_S_WAIT;
							end
						end
						MBT_JMP, MBT_CALL: begin
							nxt_pc = i_instr.tgt;
							push = (i_instr.op == MBT_CALL);
							nxt_sp = push ? sp_ff + 1'b1 : sp_ff;
							nxt_wait = `MBT_BRANCH_WAIT;
							nxt_st = MBT_S_WAIT;
						end
						MBT_RET, MBT_RETX, MBT_INTERRUPT_RETURN_OP: begin
							pop = 1'b1;
							nxt_sp = sp_ff - 1'b1;
							nxt_pc = stack_ff[sp_ff - 1'b1];
							if (i_instr.op == MBT_RETX) nxt_acc = i_instr.addr;
							nxt_wait = `MBT_BRANCH_WAIT;
							nxt_st = MBT_S_WAIT;
						end
						MBT_TRD, MBT_TRDL, MBT_ITRD, MBT_ITRDL: begin
							fetch_ptr = (i_instr.op == MBT_ITRD || i_instr.op == MBT_ITRDL)
								? tptr_ff + `MBT_ONE8 : tptr_ff;
							nxt_tptr = fetch_ptr;
							nxt_paddr = (i_instr.op == MBT_TRDL || i_instr.op == MBT_ITRDL)
								? {`MBT_LAST_PAGE, `MBT_LAST_PAGE, fetch_ptr}
								: {i_table_page, fetch_ptr};
							nxt_tsect = sect;
							nxt_taddr = i_instr.addr;
							nxt_st = MBT_S_TBL;
						end
						MBT_WDTC: begin
							nxt_to = 1'b0;
							nxt_pdn = 1'b0;
						end
						MBT_HALT: begin
							nxt_to = 1'b0;
							nxt_pdn = 1'b1;
							nxt_st = MBT_S_HALT;
						end
						default: nxt_pc = pc_ff + `MBT_ONE_PC;
					endcase
				end
			end
			MBT_S_WAIT: begin
				nxt_wait = wait_ff - 2'd1;
				if (wait_ff == 2'd1) nxt_st = MBT_S_EXEC;
			end
			MBT_S_TBL: begin
				nxt_wr = '{1'b1, tsect_ff, taddr_ff, i_pmem_rdata[7:0]};
				nxt_thi = i_pmem_rdata[15:8];
				nxt_st = MBT_S_EXEC;
			end
			MBT_S_HALT: begin
				if (i_wake) nxt_st = MBT_S_EXEC;
			end
			default: nxt_st = MBT_S_EXEC;
		endcase
	end

	// Register core state
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st_ff <= MBT_S_EXEC;
			pc_ff <= `MBT_PC_RST;
			acc_ff <= `MBT_ACC_RST;
			thi_ff <= `MBT_ZERO8;
			tptr_ff <= `MBT_ZERO8;
			to_ff <= 1'b0;
			pdn_ff <= 1'b0;
			wait_ff <= 2'd0;
			wr_ff <= '0;
			tsect_ff <= `MBT_SECTOR0;
			taddr_ff <= `MBT_ZERO8;
			paddr_ff <= '0;
			sp_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			pc_ff <= nxt_pc;
			acc_ff <= nxt_acc;
			thi_ff <= nxt_thi;
			tptr_ff <= nxt_tptr;
			to_ff <= nxt_to;
			pdn_ff <= nxt_pdn;
			wait_ff <= nxt_wait;
			wr_ff <= nxt_wr;
			tsect_ff <= nxt_tsect;
			taddr_ff <= nxt_taddr;
			paddr_ff <= nxt_paddr;
			sp_ff <= nxt_sp;
		end
	end

	// Return address stack
	always_ff @(posedge i_clk_sys) begin
		if (push) stack_ff[sp_ff] <= pc_ff + `MBT_ONE_PC;
	end

	assign o_pc = pc_ff;
	assign o_accumulator_reg = acc_ff;
	assign o_table_high_byte = thi_ff;
	assign o_table_pointer = tptr_ff;
	assign o_timeout_flag = to_ff;
	assign o_powerdown_flag = pdn_ff;
	assign o_halted = (st_ff == MBT_S_HALT);
	assign o_dmem_wr = wr_ff;
	assign o_pmem_addr = paddr_ff;

	// Checks
	property p_mov_acc;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_MOV_MA)
			|=> (o_accumulator_reg == $past(rd_eff)) && o_ready;
	endproperty
	a_mov_acc: assert property (p_mov_acc) else $error("move to accumulator wrong");
	property p_mov_mem;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_MOV_AM)
			|=> o_dmem_wr.we && o_dmem_wr.data == $past(o_accumulator_reg);
	endproperty
	a_mov_mem: assert property (p_mov_mem) else $error("move to memory wrong");
	property p_imm;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_MOV_AX)
			|=> o_accumulator_reg == $past(i_instr.addr) && $stable(o_timeout_flag);
	endproperty
	a_imm: assert property (p_imm) else $error("immediate load wrong");
	property p_skip_len;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_SKZ && rd_eff == `MBT_ZERO8)
			|=> !o_ready ##1 !o_ready ##1 o_ready;
	endproperty
	a_skip_len: assert property (p_skip_len) else $error("skip length wrong");
	property p_jump;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_JMP)
			|=> o_pc == $past(i_instr.tgt) && !o_ready ##1 o_ready;
	endproperty
	a_jump: assert property (p_jump) else $error("jump timing wrong");
	property p_table;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_TRDL)
			|=> o_pmem_addr[11:8] == `MBT_LAST_PAGE ##1 o_dmem_wr.we && o_ready;
	endproperty
	a_table: assert property (p_table) else $error("last page fetch wrong");
	property p_wdt;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_WDTC) |=> !o_timeout_flag && !o_powerdown_flag;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
	property p_halt;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_ready && i_valid && i_instr.op == MBT_HALT) |=> o_halted && o_powerdown_flag;
	endproperty
	a_halt: assert property (p_halt) else $error("halt wrong");
	property p_sector;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_valid && !i_instr.ext) |-> o_dmem_sect == `MBT_SECTOR0;
	endproperty
	a_sector: assert property (p_sector) else $error("sector select wrong");
endmodule

/* inc/mbt_defs.svh */
`ifndef MBT_DEFS_SVH
`define MBT_DEFS_SVH
`define MBT_W_OP 5
`define MBT_W_PC 12
`define MBT_PC_RST 12'h000
`define MBT_ACC_RST 8'h00
`define MBT_ZERO8 8'h00
`define MBT_ONES8 8'hff
`define MBT_ONE8 8'h01
`define MBT_ONE_PC 12'h001
`define MBT_TWO_PC 12'h002
`define MBT_LAST_PAGE 4'hf
`define MBT_SECTOR0 2'h0
`define MBT_SKIP_WAIT 2'h2
`define MBT_BRANCH_WAIT 2'h1
`endif

/* inc/mbt_pkg.sv */
package mbt_pkg;
	// Operation codes of the covered instruction groups
	typedef enum logic [4:0] {
		MBT_NOP = 5'h00, MBT_MOV_MA = 5'h01, MBT_MOV_AM = 5'h02, MBT_MOV_AX = 5'h03,
		MBT_BCLR = 5'h04, MBT_BSET = 5'h05, MBT_JMP = 5'h06, MBT_SKZ = 5'h07,
		MBT_SKZM = 5'h08, MBT_SKNZ = 5'h09, MBT_SKBZ = 5'h0a, MBT_SKBNZ = 5'h0b,
		MBT_INCSK = 5'h0c, MBT_DECSK = 5'h0d, MBT_INCSKA = 5'h0e, MBT_DECSKA = 5'h0f,
		MBT_CALL = 5'h10, MBT_RET = 5'h11, MBT_RETX = 5'h12, MBT_INTERRUPT_RETURN_OP = 5'h13,
		MBT_TRD = 5'h14, MBT_TRDL = 5'h15, MBT_ITRD = 5'h16, MBT_ITRDL = 5'h17,
		MBT_CLRM = 5'h18, MBT_SETM = 5'h19, MBT_SWAP = 5'h1a, MBT_SWAPACC = 5'h1b,
		MBT_WDTC = 5'h1c, MBT_HALT = 5'h1d
	} mbt_op_t;
	// Decoded instruction
	typedef struct packed {
		mbt_op_t op;
		logic ext;        // Extended form: sector field is used
		logic [1:0] sect; // Data memory sector
		logic [7:0] addr; // Data address or immediate
		logic [2:0] bitn; // Bit number 0..7
		logic [11:0] tgt; // Branch target
	} mbt_instr_t;
	// Data memory write request
	typedef struct packed {
		logic we;
		logic [1:0] sect;
		logic [7:0] addr;
		logic [7:0] data;
	} mbt_dwr_t;
	typedef enum logic [1:0] {
		MBT_S_EXEC = 2'b00, MBT_S_WAIT = 2'b01, MBT_S_TBL = 2'b10, MBT_S_HALT = 2'b11
	} mbt_state_t;
endpackage

/* testbench/mbt_mem_model.sv */
// Data memory and program memory that sit beside the execute block
module mbt_mem_model (
	input wire logic i_clk_sys,
	input wire logic [1:0] i_sect,
	input wire logic [7:0] i_raddr,
	input wire mbt_pkg::mbt_dwr_t i_wr,
	input wire logic [15:0] i_paddr,
	output logic [7:0] o_rdata,
	output logic [15:0] o_pdata
);
	import mbt_pkg::*;
	logic [7:0] dm [4][256];
	// Fill every sector with a pattern so that stale reads show up
	initial begin
		for (int s = 0; s < 4; s++) begin
			for (int a = 0; a < 256; a++) begin
				dm[s][a] = 8'(a) ^ {2'(s), 6'h2a};
			end
		end
	end
	// Read data follows the address in the same cycle
	assign o_rdata = dm[i_sect][i_raddr];
	// Program word is a fixed function of its address
	assign o_pdata = {i_paddr[7:0] ^ i_paddr[15:8], ~i_paddr[7:0]};
	// One-cycle write pulse lands at the clock edge
	always @(posedge i_clk_sys) begin
		if (i_wr.we) begin
			dm[i_wr.sect][i_wr.addr] <= i_wr.data;
		end
	end
endmodule

/* testbench/mcu_move_branch_table_exec_bench.sv */
module mcu_move_branch_table_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mbt_pkg::*;
	logic clk, rst_n, valid, wake, rdy, dto, dpdf, dhalt, pdn;
	mbt_instr_t instr;
	mbt_dwr_t dwr;
	logic [1:0] dsect;
	logic [7:0] page, draddr, drdata, dacc, dtblh, dtblp, acc, thi, tptr;
	logic [15:0] paddr, pdata;
	logic [11:0] dpc, pc;
	logic [11:0] stk [$];
	int miscompares, checked, cycles, tick;
	mbt_op_t op;
	mbt_exec dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_valid(valid), .i_instr(instr),
		.i_dmem_rdata(drdata), .i_pmem_rdata(pdata), .i_table_page(page), .i_wake(wake),
		.o_ready(rdy), .o_dmem_sect(dsect), .o_dmem_raddr(draddr), .o_dmem_wr(dwr),
		.o_pmem_addr(paddr), .o_pc(dpc), .o_accumulator_reg(dacc),
		.o_table_high_byte(dtblh), .o_table_pointer(dtblp), .o_timeout_flag(dto),
		.o_powerdown_flag(dpdf), .o_halted(dhalt));
	mbt_mem_model mem (.i_clk_sys(clk), .i_sect(dsect), .i_raddr(draddr), .i_wr(dwr),
		.i_paddr(paddr), .o_rdata(drdata), .o_pdata(pdata));
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Cut a hang short
	always @(posedge clk) begin
		tick++;
		if (tick == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [15:0] pword(logic [15:0] a);
		return {a[7:0] ^ a[15:8], ~a[7:0]};
	endfunction
	task test_done;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Issue one instruction, predict its effects and compare them
	task automatic run_op(mbt_op_t o);
		logic [1:0] s;
		logic [7:0] m, nm, x;
		logic [11:0] npc;
		logic [15:0] pa, w;
		logic skp;
		int ec;
		@(negedge clk);
		instr.op = o;
		instr.ext = 1'($urandom);
		instr.sect = 2'($urandom);
		instr.addr = 8'($urandom);
		instr.bitn = 3'($urandom);
		instr.tgt = 12'($urandom);
		page = 8'($urandom);
		x = instr.addr;
		s = instr.ext ? instr.sect : 2'h0;
		case ($urandom_range(3))
			0: m = 8'h00;
			1: m = 8'hff;
			2: m = 8'h01;
			default: m = 8'($urandom);
		endcase
		mem.dm[s][x] = m;
		nm = m;
		npc = pc + 12'h001;
		skp = 1'b0;
		ec = 1;
		pa = 16'h0000;
		case (o)
			MBT_MOV_MA: acc = m;
			MBT_MOV_AM: nm = acc;
			MBT_MOV_AX: acc = x;
			MBT_BCLR: nm[instr.bitn] = 1'b0;
			MBT_BSET: nm[instr.bitn] = 1'b1;
			MBT_SKZ: skp = (m == 8'h00);
			MBT_SKNZ: skp = (m != 8'h00);
			MBT_SKBZ: skp = !m[instr.bitn];
			MBT_SKBNZ: skp = m[instr.bitn];
			MBT_CLRM: nm = 8'h00;
			MBT_SETM: nm = 8'hff;
			MBT_SWAP: nm = {m[3:0], m[7:4]};
			MBT_SWAPACC: acc = {m[3:0], m[7:4]};
			MBT_WDTC: pdn = 1'b0;
			MBT_HALT: begin
				// Wake is raised the cycle after entry, so halt lasts two cycles
				pdn = 1'b1;
				ec = 2;
			end
			MBT_SKZM: begin
				skp = (m == 8'h00);
				acc = m;
			end
			MBT_INCSK, MBT_DECSK: begin
				nm = (o == MBT_INCSK) ? m + 8'h01 : m - 8'h01;
				skp = (nm == 8'h00);
			end
			MBT_INCSKA, MBT_DECSKA: begin
				acc = (o == MBT_INCSKA) ? m + 8'h01 : m - 8'h01;
				skp = (acc == 8'h00);
			end
			MBT_JMP, MBT_CALL: begin
				if (o == MBT_CALL) begin
					stk.push_back(pc + 12'h001);
				end
				npc = instr.tgt;
				ec = 2;
			end
			MBT_RET, MBT_RETX, MBT_INTERRUPT_RETURN_OP: begin
				npc = stk.pop_back();
				if (o == MBT_RETX) begin
					acc = x;
				end
				ec = 2;
			end
			MBT_TRD, MBT_TRDL, MBT_ITRD, MBT_ITRDL: begin
				if (o inside {MBT_ITRD, MBT_ITRDL}) begin
					tptr = tptr + 8'h01;
				end
				pa = {(o inside {MBT_TRDL, MBT_ITRDL}) ? 8'hff : page, tptr};
				w = pword(pa);
				nm = w[7:0];
				thi = w[15:8];
				ec = 2;
			end
			default: ;
		endcase
		if (skp) begin
			npc = pc + 12'h002;
			ec = 3;
		end
		pc = npc;
		valid = 1'b1;
		@(posedge clk);
		@(negedge clk);
		valid = 1'b0;
		cycles = 1;
		if (ec == 2 && o inside {MBT_TRD, MBT_TRDL, MBT_ITRD, MBT_ITRDL}) begin
			chk("pmem_addr", paddr, pa);
		end
		if (o == MBT_HALT) begin
			chk("halted", 16'(dhalt), 16'h0001);
			wake = 1'b1;
		end
		while (rdy !== 1'b1 && cycles < 50) begin
			@(negedge clk);
			cycles++;
		end
		wake = 1'b0;
		@(posedge clk);
		#1;
		chk("pc", 16'(dpc), 16'(pc));
		chk("acc", 16'(dacc), 16'(acc));
		chk("mem", 16'(mem.dm[s][x]), 16'(nm));
		chk("table_high", 16'(dtblh), 16'(thi));
		chk("table_ptr", 16'(dtblp), 16'(tptr));
		chk("flags", 16'({dto, dpdf}), 16'({1'b0, pdn}));
		chk("cycles", 16'(cycles), 16'(ec));
	endtask
	// Reset, every operation in order twice (a return on an empty stack becomes a call), then a random stream
	initial begin
		rst_n = 1'b0;
		valid = 1'b0;
		wake = 1'b0;
		instr = '0;
		page = 8'h00;
		acc = 8'h00;
		thi = 8'h00;
		tptr = 8'h00;
		pc = 12'h000;
		pdn = 1'b0;
		void'($urandom(32'h28df015c));
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk("pc", 16'(dpc), 16'h0000);
		chk("ready", 16'(rdy), 16'h0001);
		for (int i = 0; i < 460; i++) begin
			op = (i < 60) ? mbt_op_t'(i % 30) : mbt_op_t'($urandom_range(29));
			if (op inside {MBT_RET, MBT_RETX, MBT_INTERRUPT_RETURN_OP} && stk.size() == 0) begin
				op = MBT_CALL;
			end else if (op == MBT_CALL && stk.size() == 8) begin
				op = MBT_RET;
			end
			run_op(op);
		end
		test_done();
	end
endmodule
